/* msp_pkg.sv */
package msp_pkg;

	localparam int MSP_MOTORS = 4;
	localparam int MSP_ADDR_W = 8;
	localparam int MSP_DATA_W = 32;

	// Register byte addresses
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
	localparam logic [7:0] OFS_CWORD0 = 8'h20;
	localparam logic [7:0] REG_STRIDE = 8'h04;

	localparam int CTRL_W = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

	// Drive-profile control word bit positions
	localparam int CW_W = 16;
	localparam int CW_SWITCH_ON = 0;
	localparam int CW_VOLTAGE = 1;
	localparam int CW_QUICK_STOP = 2;
	localparam int CW_OPERATION = 3;
	localparam int CW_NEW_TARGET = 4;
	localparam int CW_CHG_IMM = 5;
	localparam int CW_ABS_REL = 6;
	localparam int CW_FAULT_RESET = 7;
	localparam int CW_HALT = 8;
	localparam int CW_CHG_AFTER = 9;
	localparam logic [CW_W-1:0] CW_RESET = 16'h0000;

	// Per-motor fields of status and interrupt registers
	localparam int ST_STRIDE = 4;
	localparam int EV_STRIDE = 3;
	localparam int EV_START = 0;
	localparam int EV_REACHED = 1;
	localparam int EV_FAULT = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_MOVE = 2'b10
	} msp_pos_state_t;

	// Bit 0 is enable, bit 8 change-after-target-reached
	typedef struct packed {
		logic change_after_target_reached;
		logic change_immediately;
		logic abs_rel;
		logic new_target_trigger;
		logic position_mode;
		logic ctrlword_fault_reset;
		logic ctrlword_quick_stop;
		logic halt;
		logic enable;
	} msp_ctrl_t;

	typedef struct packed {
		logic connected;
		logic fault;
		logic target_reached;
	} msp_motor_in_t;

	typedef struct packed {
		logic fault;
		logic connected;
		logic target_reached_flag;
		logic busy;
	} msp_chan_stat_t;

endpackage : msp_pkg

/* msp_sync3.sv */
`timescale 1ns/1ps
module msp_sync3
	import msp_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] out_next;

	// Stage two and three must agree, filtering single-cycle glitches
	assign out_next = (s2_reg == s3_reg) ? s3_reg : sync_out;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			sync_out <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			sync_out <= out_next;
		end
	end

endmodule : msp_sync3

/* msp_motor_ctrl.sv */
// Operation
// - Halt bit stops with ramp; forwarded as control word bit 8.
// - Quick stop bit stops at once; forwarded as control word bit 2.
// - In position mode a trigger rising edge starts a move; forwarded as bit 4.
// - Unless pos_ok drops, busy clears and target reached sets only after trigger is low, or on a reached edge during a retrigger with neither change bit set.
// - Abs/rel bit 0 means absolute target, 1 means relative target.
// - In position mode abs/rel is forwarded as control word bit 6.
// - Change-immediately restarts at once with new target; forwarded as bit 5.
// - Change-after-target finishes current target first; forwarded as bit 9.
// - Enable, connected and fault-free drives motor toward operation enabled.
// - Fault reset acknowledges a fault; forwarded as control word bit 7.
`timescale 1ns/1ps
module msp_motor_ctrl
	import msp_pkg::*;
#(
	parameter int MOTORS = MSP_MOTORS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [MSP_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [MSP_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [MSP_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [MSP_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire msp_motor_in_t [MOTORS-1:0] motor_in,
	output logic [MOTORS-1:0][CW_W-1:0] control_word,
	output logic irq
);

	localparam int EV_W = MOTORS * EV_STRIDE;
	localparam int ST_W = MOTORS * ST_STRIDE;

	if (MOTORS < 1 || MOTORS > 4) begin : g_bad_motors
		$error("MOTORS must be 1 to 4 to fit the register map");
	end

	// Write channel capture
	logic aw_have_reg;
	logic w_have_reg;
	logic [MSP_ADDR_W-1:0] aw_addr_reg;
	logic [MSP_DATA_W-1:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic wr_fire;
	logic [MSP_ADDR_W-1:0] wr_word;
	logic [MSP_DATA_W-1:0] byte_mask;

	// Read channel
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [MSP_DATA_W-1:0] rdata_reg;
	logic rd_fire;
	logic [MSP_ADDR_W-1:0] rd_word;

	// Registers
	logic [MOTORS-1:0][CTRL_W-1:0] ctrl_reg;
	logic [EV_W-1:0] irq_stat_reg;
	logic [EV_W-1:0] irq_en_reg;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] clr_mask;
	logic [ST_W-1:0] status_bits;

	// Synchronised motor inputs
	msp_motor_in_t [MOTORS-1:0] min_sync;

	// Decode
	logic wr_stat_hit;
	logic wr_clr_hit;
	logic wr_en_hit;
	logic [MOTORS-1:0] wr_ctrl_hit;
	logic rd_stat_hit;
	logic rd_istat_hit;
	logic rd_en_hit;
	logic [MOTORS-1:0] rd_ctrl_hit;
	logic [MOTORS-1:0] rd_cw_hit;
	logic [MOTORS:0][MSP_DATA_W-1:0] rd_acc;
	logic [MOTORS:0] rd_any_acc;
	logic rd_mapped;
	logic wr_mapped;
	logic [MSP_DATA_W-1:0] rd_mux;

	msp_sync3 #(
		.WIDTH($bits(msp_motor_in_t) * MOTORS)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(motor_in),
		.sync_out(min_sync)
	);

	// AXI4-Lite handshakes; address and data taken in either order
	assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_have_reg & ~bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
	assign rd_fire = s_axi_arvalid & ~rvalid_reg;
	assign wr_word = {aw_addr_reg[MSP_ADDR_W-1:2], 2'b00};
	assign rd_word = {s_axi_araddr[MSP_ADDR_W-1:2], 2'b00};
	assign byte_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

	assign wr_stat_hit = wr_word == OFS_STATUS;
	assign wr_clr_hit = wr_word == OFS_IRQ_CLR;
	assign wr_en_hit = wr_word == OFS_IRQ_EN;
	assign rd_stat_hit = rd_word == OFS_STATUS;
	assign rd_istat_hit = rd_word == OFS_IRQ_STAT;
	assign rd_en_hit = rd_word == OFS_IRQ_EN;

	// Status and interrupt status are read-only; writes to them answer OKAY
	assign wr_mapped = (|wr_ctrl_hit) | wr_clr_hit | wr_en_hit | wr_stat_hit
		| (wr_word == OFS_IRQ_STAT);
	assign rd_mapped = rd_any_acc[MOTORS] | rd_stat_hit | rd_istat_hit | rd_en_hit;

	assign rd_acc[0] = '0;
	assign rd_any_acc[0] = 1'b0;
	assign rd_mux = rd_acc[MOTORS]
		| (rd_stat_hit ? MSP_DATA_W'(status_bits) : '0)
		| (rd_istat_hit ? MSP_DATA_W'(irq_stat_reg) : '0)
		| (rd_en_hit ? MSP_DATA_W'(irq_en_reg) : '0);

	// Clear register is write-only; only enabled byte lanes clear
	assign clr_mask = (wr_fire & wr_clr_hit) ? EV_W'(w_data_reg & byte_mask) : '0;

	assign irq = |(irq_stat_reg & irq_en_reg);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_have_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			w_have_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_have_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= '0;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			rdata_reg <= rd_mux;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_en_reg <= '0;
		end else if (wr_fire & wr_en_hit) begin
			irq_en_reg <= (irq_en_reg & ~EV_W'(byte_mask)) | EV_W'(w_data_reg & byte_mask);
		end
	end

	// A new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~clr_mask) | events;
		end
	end

	for (genvar m = 0; m < MOTORS; m++) begin : g_motor
		localparam logic [7:0] CTRL_OFS = 8'(OFS_CTRL0 + m * REG_STRIDE);
		localparam logic [7:0] CW_OFS = 8'(OFS_CWORD0 + m * REG_STRIDE);

		msp_ctrl_t c;
		msp_motor_in_t mi;
		msp_chan_stat_t st;
		msp_pos_state_t state_reg;
		msp_pos_state_t state_next;
		logic trig_prev_reg;
		logic trig_rise;
		logic reached_prev_reg;
		logic reached_rise;
		logic fault_prev_reg;
		logic op_en;
		logic pos_ok;
		logic pend_reg;
		logic pend_next;
		logic tr_flag_reg;
		logic tr_flag_next;
		logic ev_start;
		logic ev_done;
		logic [CW_W-1:0] cw_next;

		assign c = msp_ctrl_t'(ctrl_reg[m]);
		assign mi = min_sync[m];
		assign wr_ctrl_hit[m] = wr_word == CTRL_OFS;
		assign rd_ctrl_hit[m] = rd_word == CTRL_OFS;
		assign rd_cw_hit[m] = rd_word == CW_OFS;
		assign rd_acc[m+1] = rd_acc[m]
			| (rd_ctrl_hit[m] ? MSP_DATA_W'(ctrl_reg[m]) : '0)
			| (rd_cw_hit[m] ? MSP_DATA_W'(control_word[m]) : '0);
		assign rd_any_acc[m+1] = rd_any_acc[m] | rd_ctrl_hit[m] | rd_cw_hit[m];

		assign op_en = c.enable & mi.connected & ~mi.fault;
		assign pos_ok = c.position_mode & op_en & ~c.ctrlword_quick_stop;
		assign trig_rise = c.new_target_trigger & ~trig_prev_reg;
		assign reached_rise = mi.target_reached & ~reached_prev_reg;

		// Positioning handshake
		always_comb begin
			state_next = state_reg;
			pend_next = pend_reg;
			tr_flag_next = tr_flag_reg;
			ev_start = 1'b0;
			ev_done = 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (pos_ok & trig_rise) begin
						state_next = ST_START;
						tr_flag_next = 1'b0;
						ev_start = 1'b1;
					end
				end
				ST_START: begin
					// Held busy until the trigger drops, whatever target reached reports; loss of pos_ok returns to idle
					if (!pos_ok) begin
						state_next = ST_IDLE;
						pend_next = 1'b0;
					end else if (!c.new_target_trigger) begin
						state_next = ST_MOVE;
					end
				end
				ST_MOVE: begin
					if (!pos_ok) begin
						state_next = ST_IDLE;
						pend_next = 1'b0;
					end else if (trig_rise & c.change_immediately) begin
						state_next = ST_START;
						pend_next = 1'b0;
						ev_start = 1'b1;
					end else if (trig_rise & c.change_after_target_reached) begin
						pend_next = 1'b1;
					end else if (reached_rise & pend_reg) begin
						state_next = ST_START;
						pend_next = 1'b0;
						ev_start = 1'b1;
					end else if (reached_rise) begin
						state_next = ST_IDLE;
						tr_flag_next = 1'b1;
						ev_done = 1'b1;
					end
				end
				default: begin
					state_next = ST_IDLE;
					pend_next = 1'b0;
				end
			endcase
		end

		always_comb begin
			cw_next = CW_RESET;
			cw_next[CW_SWITCH_ON] = op_en;
			cw_next[CW_VOLTAGE] = op_en;
			cw_next[CW_OPERATION] = op_en;
			cw_next[CW_QUICK_STOP] = c.ctrlword_quick_stop;
			cw_next[CW_HALT] = c.halt;
			cw_next[CW_FAULT_RESET] = c.ctrlword_fault_reset;
			if (c.position_mode) begin
				cw_next[CW_NEW_TARGET] = c.new_target_trigger;
				cw_next[CW_ABS_REL] = c.abs_rel;
				cw_next[CW_CHG_IMM] = c.change_immediately;
				cw_next[CW_CHG_AFTER] = c.change_after_target_reached;
			end
		end

		assign st.busy = state_reg != ST_IDLE;
		assign st.target_reached_flag = tr_flag_reg;
		assign st.connected = mi.connected;
		assign st.fault = mi.fault;
		assign status_bits[m*ST_STRIDE +: ST_STRIDE] = st;
		assign events[m*EV_STRIDE + EV_START] = ev_start;
		assign events[m*EV_STRIDE + EV_REACHED] = ev_done;
		assign events[m*EV_STRIDE + EV_FAULT] = mi.fault & ~fault_prev_reg;

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				ctrl_reg[m] <= CTRL_RESET;
			end else if (wr_fire & wr_ctrl_hit[m]) begin
				ctrl_reg[m] <= (ctrl_reg[m] & ~CTRL_W'(byte_mask))
					| CTRL_W'(w_data_reg & byte_mask);
			end
		end

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				state_reg <= ST_IDLE;
				pend_reg <= 1'b0;
				tr_flag_reg <= 1'b0;
				trig_prev_reg <= 1'b0;
				reached_prev_reg <= 1'b0;
				fault_prev_reg <= 1'b0;
				control_word[m] <= CW_RESET;
			end else begin
				state_reg <= state_next;
				pend_reg <= pend_next;
				tr_flag_reg <= tr_flag_next;
				trig_prev_reg <= c.new_target_trigger;
				reached_prev_reg <= mi.target_reached;
				fault_prev_reg <= mi.fault;
				control_word[m] <= cw_next;
			end
		end
	end

endmodule : msp_motor_ctrl

/* msp_motor_ctrl_assertions.sv */
`timescale 1ns/1ps
module msp_chk
	import msp_pkg::*;
#(
	parameter int MOTORS = MSP_MOTORS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [MSP_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [MSP_DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire msp_motor_in_t [MOTORS-1:0] motor_in,
	input wire logic [MOTORS-1:0][CW_W-1:0] control_word
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire aw_w_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	a_write_answer: assert property (aw_w_both |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_read_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read not answered");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_unmapped_read: assert property (ar_take && s_axi_araddr == 8'h40 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_enable_trio: assert property (control_word[0][CW_SWITCH_ON] == control_word[0][CW_VOLTAGE] && control_word[0][CW_VOLTAGE] == control_word[0][CW_OPERATION])
		else $error("enable bits disagree");
	a_fault_blocks: assert property (motor_in[0].fault [*8] |-> !control_word[0][CW_OPERATION])
		else $error("faulty motor kept enabled");
	c_write: cover property (aw_w_both);
	c_read: cover property (ar_take);
	c_trigger: cover property ($rose(control_word[0][CW_NEW_TARGET]));
endmodule : msp_chk
bind msp_motor_ctrl msp_chk #(.MOTORS(MOTORS)) i_chk (.clk(clk), .reset_n(reset_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .motor_in(motor_in),
	.control_word(control_word));

/* msp_motor_model.sv */
`timescale 1ns/1ps
module msp_motor_model
	import msp_pkg::*;
(
	input wire logic clk,
	input wire logic fault_cmd,
	input wire logic [MSP_MOTORS-1:0][CW_W-1:0] cw,
	output msp_motor_in_t [MSP_MOTORS-1:0] motor
);
	// Starts settled so the first move needs a fresh reached edge
	logic [5:0] cnt_reg [MSP_MOTORS] = '{default: 6'h3F};
	always_ff @(posedge clk) begin
		for (int m = 0; m < MSP_MOTORS; m++) begin
			if (cw[m][CW_NEW_TARGET])
				cnt_reg[m] <= 6'h00;
			else if (cnt_reg[m] != 6'h3F)
				cnt_reg[m] <= cnt_reg[m] + 6'h01;
		end
	end
	always_comb begin
		for (int m = 0; m < MSP_MOTORS; m++) begin
			motor[m].connected = 1'b1;
			motor[m].fault = fault_cmd && (m == 0);
			// Reached only once the trigger has dropped and the move ran
			motor[m].target_reached = (cnt_reg[m] == 6'h3F) && !cw[m][CW_NEW_TARGET];
		end
	end
endmodule : msp_motor_model

/* msp_tb.sv */
`timescale 1ns/1ps
module tb
	import msp_pkg::*;
;
	logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, fault_cmd;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, irq;
	msp_motor_in_t [MSP_MOTORS-1:0] motor_in;
	logic [MSP_MOTORS-1:0][CW_W-1:0] control_word;
	int mismatches = 0;
	int checked = 0;
	msp_motor_ctrl i_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .motor_in(motor_in),
		.control_word(control_word), .irq(irq));
	msp_motor_model i_motor (.clk(clk), .fault_cmd(fault_cmd), .cw(control_word),
		.motor(motor_in));
	task automatic close_out();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (!ad && awready) begin
				ad = 1;
				awvalid <= 0;
			end
			if (!wd && wready) begin
				wd = 1;
				wvalid <= 0;
			end
		end
		while (!bvalid) @(posedge clk);
		bready <= 0;
		chk("bresp", {30'h0, bresp}, {30'h0, er});
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clk); while (!arready);
		arvalid <= 0;
		do @(posedge clk); while (!rvalid);
		rready <= 0;
		chk("rdata", rdata, e);
		chk("rresp", {30'h0, rresp}, {30'h0, er});
	endtask : rdc
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		#200000;
		mismatches++;
		close_out();
	end
	initial begin
		{reset_n, awvalid, wvalid, bready, arvalid, rready, fault_cmd} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1;
		rdc(OFS_CWORD0, 32'h0, RESP_OKAY);
		rdc(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'hFFFF, RESP_SLVERR);
		wr(OFS_CTRL0, 32'h00F, RESP_OKAY);
		repeat (8) @(posedge clk);
		rdc(OFS_CWORD0, 32'h018F, RESP_OKAY);
		wr(OFS_CTRL0, 32'h1E1, RESP_OKAY);
		rdc(OFS_CWORD0, 32'h000B, RESP_OKAY);
		wr(OFS_CTRL0, 32'h1D1, RESP_OKAY);
		rdc(OFS_CWORD0, 32'h026B, RESP_OKAY);
		wr(OFS_IRQ_EN, 32'h7, RESP_OKAY);
		wr(OFS_CTRL0, 32'h011, RESP_OKAY);
		wr(OFS_CTRL0, 32'h031, RESP_OKAY);
		rdc(OFS_CWORD0, 32'h001B, RESP_OKAY);
		repeat (80) @(posedge clk);
		// Trigger still high: the move must not be reported done
		rdc(OFS_STATUS, 32'h4445, RESP_OKAY);
		chk("irq", irq, 1);
		wr(OFS_CTRL0, 32'h011, RESP_OKAY);
		repeat (100) @(posedge clk);
		rdc(OFS_STATUS, 32'h4446, RESP_OKAY);
		wr(OFS_IRQ_STAT, 32'hFFFF, RESP_OKAY);
		rdc(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
		wr(OFS_IRQ_CLR, 32'h3, RESP_OKAY);
		rdc(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
		chk("irq", irq, 0);
		wr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
		wr(OFS_CTRL0, 32'h031, RESP_OKAY);
		rdc(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		chk("irq", irq, 0);
		// Second trigger while moving is queued until target reached
		wr(OFS_CTRL0, 32'h111, RESP_OKAY);
		wr(OFS_IRQ_CLR, 32'h1, RESP_OKAY);
		wr(OFS_CTRL0, 32'h131, RESP_OKAY);
		wr(OFS_CTRL0, 32'h111, RESP_OKAY);
		rdc(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
		repeat (80) @(posedge clk);
		// Model reaches only once, so the queued move stays busy
		rdc(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		rdc(OFS_STATUS, 32'h4445, RESP_OKAY);
		wr(OFS_IRQ_CLR, 32'h1, RESP_OKAY);
		wr(OFS_CTRL0, 32'h0B1, RESP_OKAY);
		rdc(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		fault_cmd <= 1;
		repeat (10) @(posedge clk);
		rdc(OFS_CWORD0, 32'h0030, RESP_OKAY);
		chk("control_word", {16'h0, control_word[0]}, 32'h0030);
		rdc(OFS_IRQ_STAT, 32'h5, RESP_OKAY);
		close_out();
	end
endmodule : tb
